// *** hw/traffic_conflict_fault_monitor.sv ***
`timescale 1ns/10ps
module traffic_conflict_fault_monitor
	import cmon_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Field signals
	input wire logic [NCH-1:0] red_in,
	input wire logic [NCH-1:0] yellow_in,
	input wire logic [NCH-1:0] green_in,
	input wire logic red_enable,
	input wire logic [1:0] special_fn,
	input wire logic relay_common_input,
	input wire logic red_interface_cable,
	input wire logic watchdog_in,
	// AC line levels
	input wire logic ac_below_dropout,
	input wire logic ac_above_restore,
	// Resets
	input wire logic front_reset,
	input wire logic remote_reset,
	// Switches and jumpers
	input wire logic [NCH-1:0] red_fail_en,
	input wire logic [NCH-1:0] clear_en,
	input wire logic [NCH-1:0] yellow_inhibit,
	input wire logic [NCH-1:0] dual_en,
	input wire logic gy_dual_en,
	input wire logic ctrl_type,
	input wire logic wd_latch_en,
	input wire logic wd_time_sel,
	input wire logic relay_common_invert,
	input wire logic compact_arrow_mode,
	// Status
	output logic flash_relay,
	output logic ac_led,
	output logic card_led,
	output logic mon_active,
	output logic compact_arrow_active,
	output logic red_fail_flag,
	output logic clear_flag,
	output logic dual_flag,
	output logic config_flag,
	output logic watchdog_timeout,
	output logic cable_flag,
	output logic [NCH-1:0] chan_fail
);

	function automatic ms_t qual_ms(input int idx);
		qual_ms = (idx >= Q_SF) ? SF_ON_MS : QUAL_ON_MS;
	endfunction

	run_state_e st_reg, st_next;
	logic [TICK_W-1:0] tick_cnt_reg;
	logic [NQ-1:0] raw_vec, qual;
	ms_t qcnt_reg [NQ];
	ms_t st_ms_reg, wd_gap_reg, fr_cnt_reg;
	logic [2:0] wd_tr_reg;
	logic [8:0] blink_reg;
	logic [CFG_W-1:0] cfg_now, cfg_store_reg;
	logic cfg_valid_reg, wd_prev_reg, front_prev_reg, remote_prev_reg;
	logic [NCH-1:0] red_q, yel_q, grn_q, grn_prev_reg, clr_pend_reg;
	logic [NCH-1:0] rf_hit, dual_hit, clr_hit;
	logic tick, rc_active, ren_q, rc_q, red_chk, sup_ok, reset_cmd;
	logic wd_edge, wd_run_hit, wd_start_hit, power_evt, cfg_set, cfg_clr;
	logic start_done, fault_mode, blink2, blink4;
	ms_t rf_lim, wd_lim;

	// Common millisecond timebase
	assign tick = tick_cnt_reg == TICK_W'(TICK_CYCLES - 1);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
		end
	end

	assign rc_active = relay_common_input ^ relay_common_invert;
	assign raw_vec = {special_fn, rc_active, red_enable, green_in, yellow_in,
		red_in};

	// Duration qualifiers; a drop restarts the count at once
	genvar gq;
	generate
		for (gq = 0; gq < NQ; gq++) begin : g_qual
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					qcnt_reg[gq] <= '0;
				end else if (!raw_vec[gq]) begin
					qcnt_reg[gq] <= '0;
				end else if (tick && qcnt_reg[gq] != MS_MAX) begin
					qcnt_reg[gq] <= qcnt_reg[gq] + 1'b1;
				end
			end
			assign qual[gq] = qcnt_reg[gq] >= qual_ms(gq);
		end
	endgenerate

	assign red_q = qual[Q_RED +: NCH];
	assign yel_q = qual[Q_YEL +: NCH];
	assign grn_q = qual[Q_GRN +: NCH];
	assign ren_q = qual[Q_REN];
	assign rc_q = qual[Q_RC];
	assign mon_active = st_reg == ST_RUN;
	assign red_chk = mon_active & ren_q & ~|qual[Q_SF +: 2] & ~rc_q;
	assign sup_ok = mon_active & ren_q & ~rc_q;
	assign rf_lim = ctrl_type ? RF_B_MS : RF_A_MS;
	assign wd_lim = wd_time_sel ? WD_ON_MS : WD_OFF_MS;

	// Per-channel red fail, dual and clearance checks
	genvar gc;
	generate
		for (gc = 0; gc < NCH; gc++) begin : g_chan
			ms_t rf_cnt_reg, du_cnt_reg;
			logic rf_cond, du_cond, clr_cond;
			assign rf_cond = red_chk & red_fail_en[gc] &
				~(red_q[gc] | yel_q[gc] | grn_q[gc]);
			assign du_cond = sup_ok & ((dual_en[gc] & ((red_q[gc] & yel_q[gc]) |
				(red_q[gc] & grn_q[gc]) | (yel_q[gc] & grn_q[gc]))) |
				(gy_dual_en & yel_q[gc] & grn_q[gc]));
			assign clr_cond = sup_ok & clear_en[gc] & ~yellow_inhibit[gc];
			assign rf_hit[gc] = rf_cond & (rf_cnt_reg >= rf_lim);
			assign dual_hit[gc] = du_cond & (du_cnt_reg >= DUAL_MS);
			// Green left without a full yellow: red arrives while pending
			assign clr_hit[gc] = clr_cond & clr_pend_reg[gc] & red_q[gc];
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					rf_cnt_reg <= '0;
					du_cnt_reg <= '0;
				end else begin
					if (!rf_cond) begin
						rf_cnt_reg <= '0;
					end else if (tick && rf_cnt_reg < rf_lim) begin
						rf_cnt_reg <= rf_cnt_reg + 1'b1;
					end
					if (!du_cond) begin
						du_cnt_reg <= '0;
					end else if (tick && du_cnt_reg < DUAL_MS) begin
						du_cnt_reg <= du_cnt_reg + 1'b1;
					end
				end
			end
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					grn_prev_reg[gc] <= 1'b0;
					clr_pend_reg[gc] <= 1'b0;
				end else begin
					grn_prev_reg[gc] <= grn_q[gc];
					if (grn_prev_reg[gc] && !grn_q[gc]) begin
						clr_pend_reg[gc] <= 1'b1;
					end else if (clr_hit[gc] || qcnt_reg[Q_YEL + gc] >= CLR_MS ||
						grn_q[gc]) begin
						clr_pend_reg[gc] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Reset requests; configuration needs the long front-panel hold
	assign reset_cmd = (front_reset & ~front_prev_reg) |
		(remote_reset & ~remote_prev_reg);
	assign cfg_clr = fr_cnt_reg == CFG_HOLD_MS;
	assign cfg_now = {compact_arrow_mode, relay_common_invert, wd_time_sel,
		wd_latch_en, ctrl_type, gy_dual_en, dual_en, yellow_inhibit, clear_en,
		red_fail_en};
	assign cfg_set = cfg_valid_reg & tick & (cfg_now != cfg_store_reg);

	// Watchdog supervision
	assign wd_edge = watchdog_in ^ wd_prev_reg;
	assign wd_run_hit = mon_active & (wd_gap_reg >= wd_lim);
	assign start_done = st_ms_reg >= START_MIN_MS &&
		wd_tr_reg >= 3'(WD_START_EDGES) && ac_above_restore;
	assign wd_start_hit = st_reg == ST_START && st_ms_reg >= START_MAX_MS &&
		wd_tr_reg < 3'(WD_START_EDGES);

	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			ST_START: begin
				if (ac_below_dropout) begin
					st_next = ST_DROP;
				end else if (start_done || wd_start_hit) begin
					st_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (ac_below_dropout) begin
					st_next = ST_DROP;
				end
			end
			ST_DROP: begin
				if (ac_above_restore) begin
					st_next = ST_START;
				end
			end
			default: begin
				st_next = ST_START;
			end
		endcase
	end
	assign power_evt = st_next == ST_DROP && st_reg != ST_DROP;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= ST_START;
			st_ms_reg <= '0;
			wd_tr_reg <= '0;
			wd_gap_reg <= '0;
			wd_prev_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			wd_prev_reg <= watchdog_in;
			if (st_reg != ST_START) begin
				st_ms_reg <= '0;
				wd_tr_reg <= '0;
			end else begin
				if (tick && st_ms_reg < START_MAX_MS) begin
					st_ms_reg <= st_ms_reg + 1'b1;
				end
				if (wd_edge && wd_tr_reg < 3'(WD_START_EDGES)) begin
					wd_tr_reg <= wd_tr_reg + 1'b1;
				end
			end
			if (wd_edge || !mon_active) begin
				wd_gap_reg <= '0;
			end else if (tick && wd_gap_reg < wd_lim) begin
				wd_gap_reg <= wd_gap_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			front_prev_reg <= 1'b0;
			remote_prev_reg <= 1'b0;
			fr_cnt_reg <= '0;
			cfg_valid_reg <= 1'b0;
			cfg_store_reg <= '0;
		end else begin
			front_prev_reg <= front_reset;
			remote_prev_reg <= remote_reset;
			if (!front_reset) begin
				fr_cnt_reg <= '0;
			end else if (tick && fr_cnt_reg < CFG_HOLD_MS) begin
				fr_cnt_reg <= fr_cnt_reg + 1'b1;
			end
			cfg_valid_reg <= 1'b1;
			// Settings are captured after power-up and re-taken on a clear
			if (!cfg_valid_reg || cfg_clr) begin
				cfg_store_reg <= cfg_now;
			end
		end
	end

	// Fault latches: a new event wins over a clear in the same cycle, except the power-event clear of watchdog_timeout
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			red_fail_flag <= 1'b0;
			clear_flag <= 1'b0;
			dual_flag <= 1'b0;
			config_flag <= 1'b0;
			watchdog_timeout <= 1'b0;
			cable_flag <= 1'b0;
			chan_fail <= '0;
		end else begin
			red_fail_flag <= (red_fail_flag & ~reset_cmd) | |rf_hit;
			clear_flag <= (clear_flag & ~reset_cmd) | |clr_hit;
			dual_flag <= (dual_flag & ~reset_cmd) | |dual_hit;
			chan_fail <= (chan_fail & {NCH{~reset_cmd}}) | rf_hit | clr_hit |
				dual_hit;
			config_flag <= (config_flag & ~cfg_clr) | cfg_set;
			cable_flag <= (cable_flag & ~reset_cmd) | ~red_interface_cable;
			// A timeout condition still standing as power fails is stale: with
			// wd_latch_en low the power event ends it, so it must not set the latch again
			watchdog_timeout <= ((watchdog_timeout & ~reset_cmd) | wd_run_hit |
				wd_start_hit) & ~(power_evt & ~wd_latch_en);
		end
	end

	assign fault_mode = red_fail_flag | clear_flag | dual_flag | config_flag |
		watchdog_timeout | cable_flag;
	assign blink2 = blink_reg < BLINK_HALF;
	assign blink4 = blink_reg < BLINK_Q1 ||
		(blink_reg >= BLINK_HALF && blink_reg < BLINK_Q3);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			blink_reg <= '0;
			flash_relay <= 1'b1;
			ac_led <= 1'b0;
			card_led <= 1'b0;
			compact_arrow_active <= 1'b0;
		end else begin
			if (tick) begin
				blink_reg <= (blink_reg == BLINK_LAST) ? '0 : blink_reg + 1'b1;
			end
			// The cabinet flashes during start-up, AC loss and any fault
			flash_relay <= fault_mode | (st_reg != ST_RUN);
			ac_led <= (st_reg == ST_RUN) | ((st_reg == ST_START) & blink4) |
				((st_reg == ST_DROP) & blink2);
			card_led <= config_flag & blink2;
			compact_arrow_active <= compact_arrow_mode;
		end
	end

	sequence s_start_leave;
		st_reg == ST_START ##1 st_reg == ST_RUN;
	endsequence
	sequence s_drop_entry;
		st_reg != ST_DROP ##1 st_reg == ST_DROP;
	endsequence

	property p_wd_clear_nolatch;
		@(posedge clk) disable iff (!rst_b)
		s_drop_entry and (!wd_latch_en [*2]) |=> !watchdog_timeout;
	endproperty
	a_wd_clear_nolatch: assert property (p_wd_clear_nolatch) else
		$error("watchdog fault kept over a power event");

	property p_wd_hold_latch;
		@(posedge clk) disable iff (!rst_b)
		watchdog_timeout && wd_latch_en && !reset_cmd |=> watchdog_timeout;
	endproperty
	a_wd_hold_latch: assert property (p_wd_hold_latch) else
		$error("latched watchdog fault lost without reset");

	property p_cable;
		@(posedge clk) disable iff (!rst_b)
		!red_interface_cable |=> cable_flag ##1 flash_relay;
	endproperty
	a_cable: assert property (p_cable) else
		$error("cable removal did not trip");

	property p_sf_drop;
		@(posedge clk) disable iff (!rst_b)
		!special_fn[0] |=> !qual[Q_SF];
	endproperty
	a_sf_drop: assert property (p_sf_drop) else
		$error("special function held after drop");

	property p_red_qual;
		@(posedge clk) disable iff (!rst_b)
		$rose(red_q[0]) |-> $past(qcnt_reg[0]) == QUAL_ON_MS - 14'h0001;
	endproperty
	a_red_qual: assert property (p_red_qual) else
		$error("red qualified at wrong duration");

	property p_chan_hold;
		@(posedge clk) disable iff (!rst_b)
		red_fail_flag && !reset_cmd |=> red_fail_flag && chan_fail != '0;
	endproperty
	a_chan_hold: assert property (p_chan_hold) else
		$error("red fail released without reset");

	property p_cfg_remote;
		@(posedge clk) disable iff (!rst_b)
		config_flag && !cfg_clr |=> config_flag;
	endproperty
	a_cfg_remote: assert property (p_cfg_remote) else
		$error("configuration fault cleared without long hold");

	property p_start_relay;
		@(posedge clk) disable iff (!rst_b)
		st_reg == ST_START [*2] |-> flash_relay && !mon_active;
	endproperty
	a_start_relay: assert property (p_start_relay) else
		$error("monitoring during start-up flash");

	property p_start_min;
		@(posedge clk) disable iff (!rst_b)
		s_start_leave |-> $past(st_ms_reg) >= START_MIN_MS;
	endproperty
	a_start_min: assert property (p_start_min) else
		$error("start-up flash ended too early");

	property p_wd_start;
		@(posedge clk) disable iff (!rst_b)
		wd_start_hit && !ac_below_dropout |=> watchdog_timeout && mon_active;
	endproperty
	a_wd_start: assert property (p_wd_start) else
		$error("missing start-up watchdog fault");
endmodule

// *** hw/cmon_pkg.sv ***
package cmon_pkg;
	localparam int NCH = 18;
	localparam int NQ = 3 * NCH + 4;
	localparam int CFG_W = 4 * NCH + 6;
	localparam int MS_W = 14;
	localparam int TICK_W = 18;
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
	localparam int WD_START_EDGES = 5;
	// Qualifier slice bases in the raw input vector
	localparam int Q_RED = 0;
	localparam int Q_YEL = NCH;
	localparam int Q_GRN = 2 * NCH;
	localparam int Q_REN = 3 * NCH;
	localparam int Q_RC = 3 * NCH + 1;
	localparam int Q_SF = 3 * NCH + 2;
	// Durations in milliseconds
	localparam logic [13:0] QUAL_ON_MS = 14'h01F4;
	localparam logic [13:0] SF_ON_MS = 14'h0226;
	localparam logic [13:0] RF_A_MS = 14'h03E8;
	localparam logic [13:0] RF_B_MS = 14'h05DC;
	localparam logic [13:0] DUAL_MS = 14'h01F4;
	localparam logic [13:0] CLR_MS = 14'h0A8C;
	localparam logic [13:0] CFG_HOLD_MS = 14'h0BB8;
	localparam logic [13:0] WD_ON_MS = 14'h03E8;
	localparam logic [13:0] WD_OFF_MS = 14'h05DC;
	localparam logic [13:0] START_MIN_MS = 14'h1770;
	localparam logic [13:0] START_MAX_MS = 14'h2710;
	localparam logic [13:0] MS_MAX = 14'h3FFF;
	// Indicator blink: 500 ms frame, 2 Hz and 4 Hz at half duty
	localparam logic [8:0] BLINK_LAST = 9'h1F3;
	localparam logic [8:0] BLINK_HALF = 9'h0FA;
	localparam logic [8:0] BLINK_Q1 = 9'h07D;
	localparam logic [8:0] BLINK_Q3 = 9'h177;
	typedef logic [13:0] ms_t;
	typedef enum logic [1:0] {
		ST_START = 2'b00,
		ST_RUN = 2'b01,
		ST_DROP = 2'b11
	} run_state_e;
endpackage

// *** verification/controller_model.sv ***
`timescale 1ns/10ps
module controller_model #(
	parameter int HALF = 400
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control
	input wire logic run,
	// Watchdog output
	output logic watchdog_in
);
	int cnt;
	// Toggles well inside the shortest run timeout; holds its level when off
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 0;
			watchdog_in <= 1'b0;
		end else if (run && cnt == HALF - 1) begin
			cnt <= 0;
			watchdog_in <= ~watchdog_in;
		end else if (run) begin
			cnt <= cnt + 1;
		end
	end
endmodule

// *** verification/traffic_conflict_fault_monitor_bench.sv ***
`timescale 1ns/10ps
module traffic_conflict_fault_monitor_bench;
	import cmon_pkg::*;
	localparam int TC = 4;
	logic clk = 0, rst_b = 0, red_enable = 1, relay_common_input = 0;
	logic [NCH-1:0] red_in = 18'h3FFFB, yellow_in = '0, green_in = '0;
	logic [NCH-1:0] red_fail_en = 18'h00001, clear_en = 18'h00004;
	logic [NCH-1:0] yellow_inhibit = '0, dual_en = '1;
	logic [1:0] special_fn = 2'h0;
	logic red_interface_cable = 1, ac_below_dropout = 0;
	logic ac_above_restore = 1, front_reset = 0, remote_reset = 0;
	logic gy_dual_en = 0, ctrl_type = 0, wd_latch_en = 0, wd_time_sel = 1;
	logic relay_common_invert = 0, compact_arrow_mode = 0, wd_run = 1;
	logic watchdog_in, flash_relay, ac_led, card_led, mon_active;
	logic compact_arrow_active, red_fail_flag, clear_flag, dual_flag;
	logic config_flag, watchdog_timeout, cable_flag;
	logic [NCH-1:0] chan_fail;
	int failures = 0, checks = 0, waited;

	traffic_conflict_fault_monitor #(.TICK_CYCLES(TC)) dut (
		.clk, .rst_b, .red_in, .yellow_in, .green_in, .red_enable,
		.special_fn, .relay_common_input, .red_interface_cable,
		.watchdog_in, .ac_below_dropout, .ac_above_restore, .front_reset,
		.remote_reset, .red_fail_en, .clear_en, .yellow_inhibit, .dual_en,
		.gy_dual_en, .ctrl_type, .wd_latch_en, .wd_time_sel,
		.relay_common_invert, .compact_arrow_mode, .flash_relay, .ac_led,
		.card_led, .mon_active, .compact_arrow_active, .red_fail_flag,
		.clear_flag, .dual_flag, .config_flag, .watchdog_timeout,
		.cable_flag, .chan_fail
	);
	controller_model #(.HALF(100 * TC)) ctrl (
		.clk, .rst_b, .run(wd_run), .watchdog_in
	);

	always #2.5 clk = ~clk;

	task complete_run;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task chk(logic ok, string m);
		checks++;
		if (ok !== 1'b1) begin
			failures++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask
	task ms(int n);
		repeat (n * TC) @(posedge clk);
		#1;
	endtask
	function logic pick(int k);
		case (k)
			1: return red_fail_flag;
			2: return dual_flag;
			3: return config_flag;
			4: return watchdog_timeout;
			5: return cable_flag;
			6: return ac_led;
			8: return clear_flag;
			default: return card_led;
		endcase
	endfunction
	// Bounded wait; the cycle count is left in waited for timing checks
	task wait_sig(int k, logic v, int lim);
		waited = 0;
		while (pick(k) !== v && waited < lim * TC) begin
			@(posedge clk);
			#1;
			waited++;
		end
		chk(pick(k) === v, "wait ran out");
		if (pick(k) !== v) complete_run();
	endtask
	task pulse_remote;
		remote_reset = 1;
		ms(1);
		remote_reset = 0;
		ms(1);
	endtask

	task t_start(logic relay_exp);
		int n, rises;
		logic prev;
		n = 0;
		rises = 0;
		prev = ac_led;
		while (mon_active !== 1'b1 && n < 11000 * TC) begin
			chk(flash_relay === 1'b1, "relay open in start-up");
			if (ac_led === 1'b1 && prev === 1'b0) rises++;
			prev = ac_led;
			@(posedge clk);
			#1;
			n++;
		end
		chk(n >= 6000 * TC && n <= 10000 * TC + TC, "start-up length");
		chk(rises >= 20 && rises <= 28, "start-up blink rate");
		if (mon_active !== 1'b1) complete_run();
		ms(130);
		chk(flash_relay === relay_exp, "relay after start-up");
		chk(ac_led === 1'b1, "ac led not steady");
		ms(130);
		chk(ac_led === 1'b1, "ac led not steady");
		chk(compact_arrow_active === 1'b0, "arrow mode");
		$display("test start-up done");
	endtask

	task t_redfail;
		special_fn[0] = 1;
		ms(600);
		red_in[0] = 0;
		ms(1100);
		chk(red_fail_flag === 1'b0, "red fail under special fn");
		red_in[0] = 1;
		special_fn[0] = 0;
		ms(600);
		red_in[0] = 0;
		ms(700);
		chk(red_fail_flag === 1'b0, "red fail early");
		wait_sig(1, 1'b1, 400);
		chk(chan_fail === 18'h00001, "channel not marked");
		// The relay follows the fault latch one cycle later
		ms(1);
		chk(flash_relay === 1'b1, "no flash on fault");
		red_in[0] = 1;
		ms(600);
		chk(red_fail_flag === 1'b1, "red fail not held");
		pulse_remote();
		chk(red_fail_flag === 1'b0 && chan_fail === '0, "remote reset");
		$display("test red fail done");
	endtask

	task t_config;
		gy_dual_en = 1;
		wait_sig(3, 1'b1, 5);
		wait_sig(7, 1'b1, 600);
		pulse_remote();
		chk(config_flag === 1'b1, "remote cleared config");
		front_reset = 1;
		ms(2900);
		chk(config_flag === 1'b1, "short hold cleared config");
		wait_sig(3, 1'b0, 200);
		front_reset = 0;
		ms(2);
		chk(config_flag === 1'b0, "config fault back");
		$display("test config done");
	endtask

	task t_dual;
		green_in[1] = 1;
		ms(900);
		chk(dual_flag === 1'b0, "dual early");
		wait_sig(2, 1'b1, 300);
		chk(chan_fail[1] === 1'b1, "dual channel");
		green_in[1] = 0;
		ms(300);
		chk(dual_flag === 1'b1, "dual not held");
		$display("test dual done");
	endtask

	// Channel 2 goes from green straight to red with no yellow
	task t_clear;
		green_in[2] = 1;
		ms(600);
		green_in[2] = 0;
		red_in[2] = 1;
		ms(400);
		chk(clear_flag === 1'b0, "clearance early");
		wait_sig(8, 1'b1, 200);
		chk(chan_fail[2] === 1'b1, "clearance channel");
		$display("test clearance done");
	endtask

	task t_watchdog_ac;
		wd_run = 0;
		// The last toggle may lie up to 100 ms back
		ms(880);
		chk(watchdog_timeout === 1'b0, "watchdog early");
		wait_sig(4, 1'b1, 300);
		ac_below_dropout = 1;
		ac_above_restore = 0;
		ms(5);
		chk(watchdog_timeout === 1'b0, "watchdog kept");
		chk(mon_active === 1'b0 && flash_relay === 1'b1, "drop");
		// Sync to a full high phase before timing it
		wait_sig(6, 1'b0, 300);
		wait_sig(6, 1'b1, 300);
		wait_sig(6, 1'b0, 300);
		chk(waited >= 240 * TC && waited <= 260 * TC, "drop blink");
		ac_below_dropout = 0;
		ac_above_restore = 1;
		wd_run = 1;
		t_start(1'b1);
		chk(dual_flag === 1'b1 && chan_fail[1] === 1'b1, "fault lost");
		chk(clear_flag === 1'b1 && chan_fail[2] === 1'b1, "clear lost");
		$display("test watchdog and ac done");
	endtask

	task t_cable;
		pulse_remote();
		chk(flash_relay === 1'b0, "faults not reset");
		red_interface_cable = 0;
		wait_sig(5, 1'b1, 600);
		ms(1);
		chk(flash_relay === 1'b1, "no flash on cable");
		red_interface_cable = 1;
		pulse_remote();
		chk(cable_flag === 1'b0, "cable flag held");
		$display("test cable done");
	endtask

	initial begin
		repeat (10) @(posedge clk);
		#1;
		chk(flash_relay === 1'b1 && mon_active === 1'b0, "reset state");
		rst_b = 1;
		t_start(1'b0);
		t_redfail();
		t_config();
		t_dual();
		t_clear();
		t_watchdog_ac();
		t_cable();
		complete_run();
	end
endmodule
